//--- hdl/mbpwm_timer.sv
// Overview of operation
// - a 32-bit counter advances once every prescale+1 ticks through a 32-bit prescaler.
// - ticks are clock cycles in timer mode or rising edges of a chosen capture input in counter mode.
// - seven match registers serve six single-edge or three double-edge pwm outputs or a mix.
// - each match can keep counting, stop or reset the counter, each optionally interrupting.
// - match zero resets the count and so sets the one period shared by all pwm outputs.
// - a single-edge output rises at the period match and falls at its own match register.
// - single-edge outputs rise at every period start unless set up to stay constantly low.
// - a double-edge output rises on one match register and falls on the next one.
// - period, width and both edges can sit at any count within the cycle.
// - in pwm mode new match values act only after software releases them and only at a period boundary; with it off they act at once.
// - with pwm mode off the block is a plain timer with match and capture and no pwm.
// - capture channels copy the count on a chosen input edge and may interrupt.
// - each external match output is set low, set high, toggled or left alone on its match.
`timescale 1ns/100ps
module mbpwm_timer
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [7:0]                    paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic [mbpwm_pkg::NUM_CAP-1:0] cap_i,
  output logic      [mbpwm_pkg::NUM_PWM-1:0] pwm_o,
  output logic      [mbpwm_pkg::NUM_EXT-1:0] ext_match_o,
  output logic                               irq_o
);
  import mbpwm_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [CTRL_W-1:0]          ctrl;
  logic [31:0]                prescale;
  logic [31:0]                tc;
  logic [31:0]                pc;
  logic [NUM_MATCH*MCR_W-1:0] mcr;
  logic [NUM_EXT*EMR_W-1:0]   emr;
  logic [PSEL_W-1:0]          pwm_sel;
  logic [NUM_MATCH-1:0]       latch_en;
  logic [NUM_CAP*CCR_W-1:0]   ccr;
  logic [31:0]                shadow [NUM_MATCH];
  logic [31:0]                active [NUM_MATCH];
  logic [31:0]                cap_val [NUM_CAP];
  logic [NUM_IRQ-1:0]         status;
  logic [NUM_IRQ-1:0]         irq_en;
  logic [NUM_CAP-1:0]         s1;
  logic [NUM_CAP-1:0]         s2;
  logic [NUM_CAP-1:0]         s3;
  logic [NUM_CAP-1:0]         lvl;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic ext_next(input logic [1:0] act, input logic q);
    case (act)
      EM_LOW:  return 1'b0;
      EM_HIGH: return 1'b1;
      EM_TOG:  return ~q;
      default: return q;
    endcase
  endfunction : ext_next
  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : sel_hit
  // ----------------------------------------
  // capture input synchronisers
  // ----------------------------------------
  wire [NUM_CAP-1:0] agree    = ~(s2 ^ s3);
  wire [NUM_CAP-1:0] next_lvl = (agree & s3) | (~agree & lvl);
  wire [NUM_CAP-1:0] cap_rise = next_lvl & ~lvl;
  wire [NUM_CAP-1:0] cap_fall = ~next_lvl & lvl;
  // ----------------------------------------
  // prescaler and counter
  // ----------------------------------------
  wire run      = ctrl[CTRL_EN] & ~ctrl[CTRL_RST];
  wire cnt_edge = ctrl[CTRL_CSEL] ? cap_rise[1] : cap_rise[0];
  wire tick     = run & (ctrl[CTRL_CNT] ? cnt_edge : 1'b1);
  wire step     = tick & (pc == prescale);
  wire pwm_mode = ctrl[CTRL_PWM];
  logic [NUM_MATCH-1:0] match;
  logic [NUM_MATCH-1:0] m_rst;
  logic [NUM_MATCH-1:0] m_stop;
  logic [NUM_MATCH-1:0] m_int;
  always_comb
  begin
    for (int i = 0; i < NUM_MATCH; i++)
    begin
      match[i]  = step & (tc == active[i]);
      m_rst[i]  = match[i] & mcr[i*MCR_W+MCR_RST];
      m_stop[i] = match[i] & mcr[i*MCR_W+MCR_STOP];
      m_int[i]  = match[i] & mcr[i*MCR_W+MCR_INT];
    end
  end
  wire any_rst  = |m_rst;
  wire any_stop = |m_stop;
  wire period   = m_rst[0];
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tc <= RST_WORD;
      pc <= RST_WORD;
    end
    else if (ctrl[CTRL_RST])
    begin
      tc <= RST_WORD;
      pc <= RST_WORD;
    end
    else if (step)
    begin
      pc <= RST_WORD;
      tc <= any_rst ? RST_WORD : tc + 32'h0000_0001;
    end
    else if (tick)
      pc <= pc + 32'h0000_0001;
  end
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = psel_i & ~penable_i;
  wire wr    = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
  wire [7:0] mr_rel = paddr_i - OFF_MR0;
  wire [7:0] mr_idx = mr_rel >> 2;
  wire is_mr = (paddr_i >= OFF_MR0) && (mr_idx < 8'(NUM_MATCH)) && (paddr_i[1:0] == 2'h0);
  logic [31:0] rdata;
  logic        hit;
  always_comb
  begin
    rdata = RST_WORD;
    hit   = 1'b1;
    if (sel_hit(paddr_i, OFF_CTRL))
      rdata = 32'(ctrl);
    else if (sel_hit(paddr_i, OFF_PRE))
      rdata = prescale;
    else if (sel_hit(paddr_i, OFF_TC))
      rdata = tc;
    else if (sel_hit(paddr_i, OFF_PC))
      rdata = pc;
    else if (sel_hit(paddr_i, OFF_MCR))
      rdata = 32'(mcr);
    else if (sel_hit(paddr_i, OFF_EMR))
      rdata = 32'(emr);
    else if (sel_hit(paddr_i, OFF_PSEL))
      rdata = 32'(pwm_sel);
    else if (sel_hit(paddr_i, OFF_LATCH))
      rdata = 32'(latch_en);
    else if (sel_hit(paddr_i, OFF_CCR))
      rdata = 32'(ccr);
    else if (sel_hit(paddr_i, OFF_CAP0))
      rdata = cap_val[0];
    else if (sel_hit(paddr_i, OFF_CAP1))
      rdata = cap_val[1];
    else if (is_mr)
      rdata = shadow[mr_idx[2:0]];
    else if (sel_hit(paddr_i, OFF_STAT))
      rdata = 32'(status);
    else if (sel_hit(paddr_i, OFF_ICLR))
      rdata = RST_WORD;
    else if (sel_hit(paddr_i, OFF_IEN))
      rdata = 32'(irq_en);
    else if (sel_hit(paddr_i, OFF_PINS))
      rdata = {16'h0000, 4'(ext_match_o), 6'h00, pwm_o};
    else
      hit = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= RST_WORD;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit;
      if (setup)
        prdata_o <= rdata;
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl     <= '0;
      prescale <= RST_WORD;
      mcr      <= '0;
      emr      <= '0;
      pwm_sel  <= '0;
      ccr      <= '0;
      irq_en   <= '0;
    end
    else
    begin
      if (wr && sel_hit(paddr_i, OFF_CTRL))
        ctrl <= pwdata_i[CTRL_W-1:0];
      // a stop match beats a same-cycle software write
      if (any_stop)
        ctrl[CTRL_EN] <= 1'b0;
      if (wr && sel_hit(paddr_i, OFF_PRE))
        prescale <= pwdata_i;
      if (wr && sel_hit(paddr_i, OFF_MCR))
        mcr <= pwdata_i[NUM_MATCH*MCR_W-1:0];
      if (wr && sel_hit(paddr_i, OFF_EMR))
        emr <= pwdata_i[NUM_EXT*EMR_W-1:0];
      if (wr && sel_hit(paddr_i, OFF_PSEL))
        pwm_sel <= pwdata_i[PSEL_W-1:0];
      if (wr && sel_hit(paddr_i, OFF_CCR))
        ccr <= pwdata_i[NUM_CAP*CCR_W-1:0];
      if (wr && sel_hit(paddr_i, OFF_IEN))
        irq_en <= pwdata_i[NUM_IRQ-1:0];
    end
  end
  // ----------------------------------------
  // match registers: shadow, release, active
  // ----------------------------------------
  // release bits clear when their value is taken; a same-cycle write re-arms them
  wire                 latch_wr   = wr & sel_hit(paddr_i, OFF_LATCH);
  wire [NUM_MATCH-1:0] take       = pwm_mode ? (period ? latch_en : '0) : {NUM_MATCH{1'b1}};
  wire [NUM_MATCH-1:0] next_latch = latch_wr ? (latch_en | pwdata_i[NUM_MATCH-1:0]) : (latch_en & ~take);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latch_en <= '0;
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        shadow[i] <= RST_WORD;
        active[i] <= RST_WORD;
      end
    end
    else
    begin
      latch_en <= next_latch;
      for (int i = 0; i < NUM_MATCH; i++)
      begin
        if (wr && is_mr && mr_idx[2:0] == 3'(i))
          shadow[i] <= pwdata_i;
        if (take[i])
          active[i] <= shadow[i];
      end
    end
  end
  // ----------------------------------------
  // pwm outputs
  // ----------------------------------------
  logic [NUM_PWM-1:0] next_pwm;
  logic [NUM_EXT-1:0] next_ext;
  always_comb
  begin
    for (int n = 0; n < NUM_PWM; n++)
    begin
      // output n+1 falls on match n+1; rises on match n when double edge, else on match zero
      logic dbl;
      logic rise;
      logic fall;
      dbl  = (n != 0) & pwm_sel[PSEL_DBL+n];
      rise = dbl ? match[n] : period;
      fall = match[n+1];
      // fall wins a tie, so a fall match equal to the period match keeps the pin low
      if (!pwm_mode || !pwm_sel[PSEL_ENA+n])
        next_pwm[n] = 1'b0;
      else if (fall)
        next_pwm[n] = 1'b0;
      else if (rise)
        next_pwm[n] = 1'b1;
      else
        next_pwm[n] = pwm_o[n];
    end
    for (int j = 0; j < NUM_EXT; j++)
      next_ext[j] = match[j] ? ext_next(emr[j*EMR_W +: EMR_W], ext_match_o[j]) : ext_match_o[j];
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1          <= '0;
      s2          <= '0;
      s3          <= '0;
      lvl         <= '0;
      pwm_o       <= '0;
      ext_match_o <= '0;
    end
    else
    begin
      s1          <= cap_i;
      s2          <= s1;
      s3          <= s2;
      lvl         <= next_lvl;
      pwm_o       <= next_pwm;
      ext_match_o <= next_ext;
    end
  end
  // ----------------------------------------
  // capture and interrupts
  // ----------------------------------------
  logic [NUM_CAP-1:0] cap_ev;
  logic [NUM_CAP-1:0] cap_int;
  always_comb
  begin
    for (int k = 0; k < NUM_CAP; k++)
    begin
      cap_ev[k]  = (ccr[k*CCR_W+CCR_RISE] & cap_rise[k]) | (ccr[k*CCR_W+CCR_FALL] & cap_fall[k]);
      cap_int[k] = cap_ev[k] & ccr[k*CCR_W+CCR_INT];
    end
  end
  wire [NUM_IRQ-1:0] ev_set  = {cap_int, m_int};
  wire [NUM_IRQ-1:0] ev_clr  = (wr && sel_hit(paddr_i, OFF_ICLR)) ? pwdata_i[NUM_IRQ-1:0] : '0;
  // set beats clear so an event landing on the clear write is kept
  wire [NUM_IRQ-1:0] next_st = (status & ~ev_clr) | ev_set;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status <= '0;
      irq_o  <= 1'b0;
      for (int k = 0; k < NUM_CAP; k++)
        cap_val[k] <= RST_WORD;
    end
    else
    begin
      status <= next_st;
      irq_o  <= |(next_st & irq_en);
      for (int k = 0; k < NUM_CAP; k++)
        if (cap_ev[k])
          cap_val[k] <= tc;
    end
  end
endmodule : mbpwm_timer

//--- include/mbpwm_pkg.sv
package mbpwm_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_MATCH = 7;
  localparam int NUM_PWM   = 6;
  localparam int NUM_EXT   = 4;
  localparam int NUM_CAP   = 2;
  localparam int NUM_IRQ   = NUM_MATCH + NUM_CAP;
  localparam int MCR_W     = 3;
  localparam int CCR_W     = 3;
  localparam int EMR_W     = 2;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PRE   = 8'h04;
  localparam logic [7:0] OFF_TC    = 8'h08;
  localparam logic [7:0] OFF_PC    = 8'h0C;
  localparam logic [7:0] OFF_MCR   = 8'h10;
  localparam logic [7:0] OFF_EMR   = 8'h14;
  localparam logic [7:0] OFF_PSEL  = 8'h18;
  localparam logic [7:0] OFF_LATCH = 8'h1C;
  localparam logic [7:0] OFF_CCR   = 8'h20;
  localparam logic [7:0] OFF_CAP0  = 8'h24;
  localparam logic [7:0] OFF_CAP1  = 8'h28;
  localparam logic [7:0] OFF_MR0   = 8'h30;
  localparam logic [7:0] OFF_STAT  = 8'h50;
  localparam logic [7:0] OFF_ICLR  = 8'h54;
  localparam logic [7:0] OFF_IEN   = 8'h58;
  localparam logic [7:0] OFF_PINS  = 8'h5C;
  localparam logic [7:0] MR_STRIDE = 8'h04;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EN   = 0;
  localparam int CTRL_RST  = 1;
  localparam int CTRL_PWM  = 2;
  localparam int CTRL_CNT  = 3;
  localparam int CTRL_CSEL = 4;
  localparam int CTRL_W    = 5;
  localparam int MCR_INT   = 0;
  localparam int MCR_RST   = 1;
  localparam int MCR_STOP  = 2;
  localparam int CCR_RISE  = 0;
  localparam int CCR_FALL  = 1;
  localparam int CCR_INT   = 2;
  localparam int PSEL_DBL  = 0;
  localparam int PSEL_ENA  = 8;
  localparam int PSEL_W    = 16;
  localparam int ST_CAP    = NUM_MATCH;
  // ----------------------------------------
  // external match actions
  // ----------------------------------------
  localparam logic [1:0] EM_NONE = 2'h0;
  localparam logic [1:0] EM_LOW  = 2'h1;
  localparam logic [1:0] EM_HIGH = 2'h2;
  localparam logic [1:0] EM_TOG  = 2'h3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : mbpwm_pkg

//--- testbench/mbpwm_chk.sv
`timescale 1ns/100ps
module mbpwm_chk
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [7:0]                    paddr_i,
  input  wire logic [31:0]                   prdata_o,
  input  wire logic                          pready_o,
  input  wire logic                          pslverr_o,
  input  wire logic [mbpwm_pkg::NUM_PWM-1:0] pwm_o,
  input  wire logic [mbpwm_pkg::NUM_EXT-1:0] ext_match_o,
  input  wire logic                          irq_o
);
  import mbpwm_pkg::*;
  logic wrote;
  wire  setup = psel_i && !penable_i;
  wire  wacc  = psel_i && penable_i && pwrite_i && pready_o;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wrote <= 1'b0;
    else if (wacc)
      wrote <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // bus and outputs
  // ----------------------------------------
  a_ready_after_setup: assert property (setup |=> pready_o && psel_i && penable_i) else $error("no ready");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_err_reads_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error");
  a_err_on_hole: assert property (setup && paddr_i == 8'h2C |=> pslverr_o) else $error("hole accepted");
  a_ok_on_match: assert property (setup && paddr_i == OFF_MR0 |=> !pslverr_o) else $error("match refused");
  a_rdata_hold: assert property ($changed(prdata_o) |-> $past(setup)) else $error("read data moved");
  a_quiet_unset: assert property (!wrote |-> pwm_o == '0 && ext_match_o == '0 && !irq_o) else $error("idle out");
  a_irq_fall_write: assert property ($fell(irq_o) |-> $past(wacc) || $past(wacc, 2)) else $error("irq dropped");
  c_irq: cover property (wrote && $rose(irq_o));
  c_pwm: cover property ($rose(pwm_o[0]));
  c_ext: cover property ($rose(ext_match_o[0]));
  c_err: cover property ($rose(pslverr_o));
endmodule : mbpwm_chk

bind mbpwm_timer mbpwm_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pwm_o(pwm_o), .ext_match_o(ext_match_o), .irq_o(irq_o));

//--- testbench/mbpwm_load.sv
`timescale 1ns/100ps
// loads on the pins: integrates on-time of two pwm lines and feeds sense lines back to capture
module mbpwm_load
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [mbpwm_pkg::NUM_PWM-1:0] pwm_i,
  input  wire logic [mbpwm_pkg::NUM_EXT-1:0] ext_i,
  input  wire logic                          pulse_i,
  output logic      [mbpwm_pkg::NUM_CAP-1:0] cap_o,
  output int                                 on_cnt_o [2]
);
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap_o       <= '0;
      on_cnt_o[0] <= 0;
      on_cnt_o[1] <= 0;
    end
    else
    begin
      // one flop of wiring delay, like a real sense path
      cap_o       <= {pulse_i, ext_i[0]};
      on_cnt_o[0] <= on_cnt_o[0] + int'(pwm_i[0]);
      on_cnt_o[1] <= on_cnt_o[1] + int'(pwm_i[1]);
    end
  end
endmodule : mbpwm_load

//--- testbench/mbpwm_timer_tb_top.sv
`timescale 1ns/100ps
module mbpwm_timer_tb_top;
  import mbpwm_pkg::*;
  logic               clk_i     = 1'b0;
  logic               rst_n_i   = 1'b0;
  logic               psel_i    = 1'b0;
  logic               penable_i = 1'b0;
  logic               pwrite_i  = 1'b0;
  logic [7:0]         paddr_i   = 8'h00;
  logic [31:0]        pwdata_i  = 32'h0;
  logic               pulse     = 1'b0;
  logic [31:0]        prdata_o, rd, lfsr;
  logic               pready_o, pslverr_o, irq_o, err;
  logic [NUM_CAP-1:0] cap_i;
  logic [NUM_PWM-1:0] pwm_o;
  logic [NUM_EXT-1:0] ext_match_o;
  int                 on_cnt [2];
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 p, n, w, c;
  logic [7:0] offs [5] = '{OFF_CTRL, OFF_PRE, OFF_TC, OFF_MR0, OFF_STAT};
  logic [1:0] ems  [4] = '{EM_HIGH, EM_NONE, EM_LOW, EM_TOG};
  logic       exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int         dbl  [2][2] = '{'{2, 6}, '{6, 2}};
  always #10 clk_i = ~clk_i;
  mbpwm_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cap_i(cap_i), .pwm_o(pwm_o), .ext_match_o(ext_match_o), .irq_o(irq_o));
  mbpwm_load u_load (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwm_i(pwm_o), .ext_i(ext_match_o), .pulse_i(pulse),
    .cap_o(cap_i), .on_cnt_o(on_cnt));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic int exp_single(int n, int w, int p);
    return (w == n) ? 0 : 4 * (w + 1) * (p + 1);
  endfunction : exp_single
  function automatic int exp_double(int n, int r, int f);
    return 4 * ((r < f) ? f - r : n + 1 - (r - f));
  endfunction : exp_double
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t pin=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin
  // setup cycle, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    rd        = prdata_o;
    err       = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 20)
    begin
      miscompares++;
      complete_run();
    end
    // let this edge's register updates land before anyone looks
    #1;
  endtask : apb
  task automatic measure(input int k, input int n, input int p, output int cnt);
    int h;
    repeat (2 * (n + 1) * (p + 1)) @(posedge clk_i);
    h = on_cnt[k];
    repeat (4 * (n + 1) * (p + 1)) @(posedge clk_i);
    cnt = on_cnt[k] - h;
  endtask : measure
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    lfsr = 32'd42;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      cmp(rd, RST_WORD);
    end
    apb(1'b1, 8'h2C, rnd());
    cmp_pin(err, 1'b1);
    apb(1'b0, 8'h2C, 32'h0);
    cmp({rd[31:1], err}, 32'h1);
    apb(1'b1, OFF_TC, 32'h5);
    apb(1'b0, OFF_TC, 32'h0);
    cmp(rd, 32'h0);
    for (int i = 0; i < NUM_MATCH; i++)
    begin
      c = int'(rnd());
      apb(1'b1, OFF_MR0 + MR_STRIDE * 8'(i), 32'(c));
      apb(1'b0, OFF_MR0 + MR_STRIDE * 8'(i), 32'h0);
      cmp(rd, 32'(c));
    end
    // one match per run: match 0 stops and interrupts
    apb(1'b1, OFF_MR0, 32'h3);
    apb(1'b1, OFF_MCR, 32'h5);
    apb(1'b1, OFF_CCR, 32'h5);
    apb(1'b1, OFF_IEN, 32'h1);
    foreach (ems[i])
    begin
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_EMR, 32'(ems[i]));
      apb(1'b1, OFF_CTRL, 32'h1);
      repeat (20) @(posedge clk_i);
      cmp_pin(ext_match_o[0], exps[i]);
      cmp(32'(pwm_o), 32'h0);
    end
    apb(1'b0, OFF_CTRL, 32'h0);
    cmp(rd & 32'h1, 32'h0);
    apb(1'b0, OFF_TC, 32'h0);
    c = int'(rd);
    apb(1'b0, OFF_TC, 32'h0);
    cmp(rd, 32'(c));
    cmp_pin(irq_o, 1'b1);
    // the enable register reaches the pin one cycle after the write lands
    apb(1'b1, OFF_IEN, 32'h0);
    repeat (2) @(negedge clk_i);
    cmp_pin(irq_o, 1'b0);
    apb(1'b1, OFF_IEN, 32'h1);
    repeat (2) @(negedge clk_i);
    cmp_pin(irq_o, 1'b1);
    apb(1'b1, OFF_ICLR, 32'h1);
    cmp_pin(irq_o, 1'b0);
    apb(1'b0, OFF_STAT, 32'h0);
    cmp(rd & 32'h81, 32'h80);
    // single-edge output 1, random period, width and prescale; last pass is constant low
    apb(1'b1, OFF_MCR, 32'h2);
    apb(1'b1, OFF_IEN, 32'h0);
    for (int j = 0; j < 4; j++)
    begin
      p = int'(rnd() % 3);
      n = 4 + int'(rnd() % 8);
      w = (j == 3) ? n : int'(rnd() % 32'(n));
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_PSEL, 32'h0100);
      apb(1'b1, OFF_PRE, 32'(p));
      apb(1'b1, OFF_MR0, 32'(n));
      apb(1'b1, OFF_MR0 + MR_STRIDE, 32'(w));
      apb(1'b1, OFF_CTRL, 32'h5);
      measure(0, n, p, c);
      cmp(32'(c), 32'(exp_single(n, w, p)));
    end
    apb(1'b1, OFF_MR0 + MR_STRIDE, 32'h1);
    measure(0, n, p, c);
    cmp(32'(c), 32'h0);
    apb(1'b1, OFF_LATCH, 32'h2);
    measure(0, n, p, c);
    cmp(32'(c), 32'(exp_single(n, 1, p)));
    // double-edge output 2, positive then negative pulse
    foreach (dbl[i])
    begin
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_PSEL, 32'h0202);
      apb(1'b1, OFF_PRE, 32'h0);
      apb(1'b1, OFF_MR0, 32'h9);
      apb(1'b1, OFF_MR0 + MR_STRIDE, 32'(dbl[i][0]));
      apb(1'b1, OFF_MR0 + 8'h08, 32'(dbl[i][1]));
      apb(1'b1, OFF_CTRL, 32'h5);
      measure(1, 9, 0, c);
      cmp(32'(c), 32'(exp_double(9, dbl[i][0], dbl[i][1])));
    end
    // counter mode on capture input 1, which also captures
    apb(1'b1, OFF_MCR, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_CCR, 32'h28);
    apb(1'b1, OFF_CTRL, 32'h19);
    repeat (5)
    begin
      pulse <= 1'b1;
      repeat (6) @(posedge clk_i);
      pulse <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    apb(1'b0, OFF_TC, 32'h0);
    cmp(rd, 32'h5);
    apb(1'b0, OFF_STAT, 32'h0);
    cmp(rd & 32'h100, 32'h100);
    apb(1'b0, OFF_CAP1, 32'h0);
    cmp(rd, 32'h4);
    complete_run();
  end
endmodule : mbpwm_timer_tb_top
